/* File: timer_pkg.sv */
// constants for the 8-bit timer/counter with shared prescaler
`default_nettype none
package timer_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] idx_timer_count_value = 8'h01;
  localparam logic [7:0] idx_interrupt_control = 8'h0B;
  localparam logic [7:0] idx_timer_options = 8'h81;
  localparam logic [7:0] idx_port_a_direction = 8'h85;
  localparam int addr_width = 12;
  localparam int data_width = 32;
  // timer_options field positions
  localparam int pos_clock_source_select = 5;
  localparam int pos_count_edge_select = 4;
  localparam int pos_prescaler_assign = 3;
  localparam int pos_prescale_ratio_lo = 0;
  localparam int width_prescale_ratio = 3;
  // interrupt_control field positions
  localparam int pos_overflow_irq_enable = 5;
  localparam int pos_overflow_flag = 2;
  // reset values
  localparam logic [7:0] rst_timer_count_value = 8'h00;
  localparam logic [7:0] rst_interrupt_control = 8'h00;
  localparam logic [7:0] rst_timer_options = 8'hFF;
  localparam logic [7:0] rst_port_a_direction = 8'hFF;
  // timing: four clocks per instruction cycle, phases q1..q4
  localparam logic [1:0] phase_q2 = 2'h1;
  localparam logic [1:0] phase_q4 = 2'h3;
  localparam logic [1:0] write_inhibit_cycles = 2'h2;
  localparam int prescaler_width = 8;
endpackage : timer_pkg
`default_nettype wire

/* File: prescale_if.sv */
// link between the timer control logic and the prescaler engine
`default_nettype none
interface prescale_if;
  logic q2;
  logic q4;
  logic count_mode;
  logic edge_falling;
  logic assign_wdt;
  logic [2:0] ratio;
  logic clear_pre;
  logic run;
  logic count_pulse;
  logic wdt_tick;
  modport ctrl (
    output q2, q4, count_mode, edge_falling, assign_wdt, ratio, clear_pre, run,
    input count_pulse, wdt_tick
  );
  modport engine (
    input q2, q4, count_mode, edge_falling, assign_wdt, ratio, clear_pre, run,
    output count_pulse, wdt_tick
  );
endinterface : prescale_if
`default_nettype wire

/* File: prescale_engine.sv */
// shared prescaler and phase-clock synchroniser
`default_nettype none
module prescale_engine (
  input wire logic clk,
  input wire logic rst,
  input wire logic external_count_input,
  input wire logic watchdog_osc_tick,
  prescale_if.engine pif
);
  // ------------------------------------------------------------
  // source edge
  // ------------------------------------------------------------
  logic src_level;
  logic src_prev_reg;
  logic src_edge;
  logic pre_in;
  logic out_level;
  logic [timer_pkg::prescaler_width-1:0] pre_reg;
  logic pre_bit_prev_reg;
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic direct_timer;

  assign src_level = external_count_input ^ pif.edge_falling; // RULE4
  assign src_edge = src_level & ~src_prev_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      // reset options pick falling edge with the pin idle low: level high
      src_prev_reg <= 1'b1;
    end else begin
      src_prev_reg <= src_level;
    end
  end

  // ------------------------------------------------------------
  // prescaler counter
  // ------------------------------------------------------------
  always_comb begin
    if (pif.assign_wdt) begin
      pre_in = watchdog_osc_tick; // RULE5
    end else if (pif.count_mode) begin
      pre_in = src_edge; // RULE14
    end else begin
      pre_in = pif.q4;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_reg <= '0;
    end else if (pif.clear_pre) begin
      pre_reg <= '0; // RULE15 RULE16
    end else if (pif.run && pre_in) begin
      pre_reg <= pre_reg + 8'h01; // RULE14
    end
  end

  // ratio r taps bit r: divide by two to the r plus one
  assign out_level = (pif.count_mode && pif.assign_wdt) ? src_level
                   : pre_reg[pif.ratio]; // RULE6 RULE19

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_bit_prev_reg <= 1'b0;
    end else begin
      pre_bit_prev_reg <= pre_reg[pif.ratio];
    end
  end
  assign pif.wdt_tick = pif.assign_wdt & pre_reg[pif.ratio] & ~pre_bit_prev_reg;

  // ------------------------------------------------------------
  // q2/q4 sampling
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      // start high so the idle input gives no false edge after reset
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else begin
      if (pif.q2) begin
        s1_reg <= out_level; // RULE12
      end
      if (pif.q4) begin
        s2_reg <= s1_reg; // RULE12
        s3_reg <= s2_reg;
      end
    end
  end

  assign direct_timer = ~pif.count_mode & pif.assign_wdt;
  assign pif.count_pulse = pif.run & (direct_timer ? pif.q4
                         : (pif.q4 & s2_reg & ~s3_reg)); // RULE1 RULE3 RULE13
endmodule : prescale_engine
`default_nettype wire

/* File: timer_counter.sv */
// 8-bit timer/counter with apb registers and overflow interrupt
//
// How it works
// RULE1: option bit 5 clear, no prescaler: count once per instruction cycle.
// RULE2: counter write blocks counting for two instruction cycles afterwards.
// RULE3: option bit 5 set: count edges on the external count input.
// RULE4: option bit 4 picks rising edge when clear, falling edge when set.
// RULE5: option bit 3 gives the one prescaler to counter or watchdog.
// RULE6: with prescaler on counter, ratio field divides by 2 up to 256.
// RULE7: prescaler count has no register address, cannot be read or loaded.
// RULE8: rollover from FF to 00 sets overflow flag, interrupt control bit 2.
// RULE9: interrupt request only while enable bit 5 is set.
// RULE10: flag stays set until software clears it; clear before re-enabling.
// RULE11: during sleep the counter and prescaler are stopped.
// RULE12: prescaler output or raw input is sampled on q2 and q4.
// RULE13: in counter mode the count lags the external edge by the sync.
// RULE14: shared 8-bit prescaler divides the input ahead of sync, symmetric output.
// RULE15: counter write clears prescaler while it is given to the counter.
// RULE16: watchdog clear instruction clears prescaler while given to watchdog.
// RULE17: software clears watchdog and counter before moving prescaler to watchdog.
// RULE18: software clears watchdog before moving prescaler to the counter.
// RULE19: ratio value r selects division by two to the power r plus one.
//
// Added by the designer: register access over APB.
`default_nettype none
module timer_counter (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::addr_width-1:0] paddr,
  input wire logic [timer_pkg::data_width-1:0] pwdata,
  output logic [timer_pkg::data_width-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_input,
  input wire logic watchdog_osc_tick,
  input wire logic watchdog_clear_instr,
  input wire logic sleep,
  output logic irq,
  output logic watchdog_tick,
  output logic watchdog_clear,
  output logic [7:0] port_a_direction
);
  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  typedef enum {sel_none, sel_count, sel_intctl, sel_options, sel_porta} reg_sel_t;

  function automatic reg_sel_t decode(input logic [timer_pkg::addr_width-1:0] a);
    reg_sel_t s;
    s = sel_none;
    if (a[1:0] == 2'h0) begin
      if (a[11:2] == {2'h0, timer_pkg::idx_timer_count_value}) begin
        s = sel_count;
      end else if (a[11:2] == {2'h0, timer_pkg::idx_interrupt_control}) begin
        s = sel_intctl;
      end else if (a[11:2] == {2'h0, timer_pkg::idx_timer_options}) begin
        s = sel_options;
      end else if (a[11:2] == {2'h0, timer_pkg::idx_port_a_direction}) begin
        s = sel_porta;
      end
    end
    return s;
  endfunction : decode

  logic [7:0] count_reg;
  logic [7:0] intctl_reg;
  logic [7:0] options_reg;
  logic [7:0] porta_reg;
  logic [1:0] phase_reg;
  logic [1:0] inhibit_reg;
  logic [timer_pkg::data_width-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  logic wdt_tick_reg;
  logic wdt_clear_reg;
  reg_sel_t sel;
  logic setup;
  logic access;
  logic wr_count;
  logic wr_intctl;
  logic wr_options;
  logic wr_porta;
  logic increment;
  logic overflow;
  logic [7:0] rd_value;

  prescale_if pif ();

  assign sel = decode(paddr);
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_reg;
  assign wr_count = access & pwrite & (sel == sel_count);
  assign wr_intctl = access & pwrite & (sel == sel_intctl);
  assign wr_options = access & pwrite & (sel == sel_options);
  assign wr_porta = access & pwrite & (sel == sel_porta);

  // ------------------------------------------------------------
  // apb slave, zero wait states
  // ------------------------------------------------------------
  // prescaler count is absent from this map
  always_comb begin
    unique case (sel)
      sel_count: rd_value = count_reg;
      sel_intctl: rd_value = intctl_reg;
      sel_options: rd_value = options_reg;
      sel_porta: rd_value = porta_reg;
      sel_none: rd_value = 8'h00; // RULE7
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        pslverr_reg <= (sel == sel_none);
        prdata_reg <= {24'h000000, rd_value};
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // instruction phase clock
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // prescaler engine hookup
  // ------------------------------------------------------------
  assign pif.q2 = (phase_reg == timer_pkg::phase_q2);
  assign pif.q4 = (phase_reg == timer_pkg::phase_q4);
  assign pif.count_mode = options_reg[timer_pkg::pos_clock_source_select]; // RULE3
  assign pif.edge_falling = options_reg[timer_pkg::pos_count_edge_select]; // RULE4
  assign pif.assign_wdt = options_reg[timer_pkg::pos_prescaler_assign]; // RULE5
  assign pif.ratio = options_reg[timer_pkg::pos_prescale_ratio_lo +:
                                 timer_pkg::width_prescale_ratio]; // RULE6
  assign pif.clear_pre = (wr_count & ~pif.assign_wdt)
                       | (watchdog_clear_instr & pif.assign_wdt); // RULE15 RULE16
  assign pif.run = ~sleep; // RULE11

  prescale_engine engine_i (
    .clk(clk),
    .rst(rst),
    .external_count_input(external_count_input),
    .watchdog_osc_tick(watchdog_osc_tick),
    .pif(pif)
  );

  // ------------------------------------------------------------
  // counter and write inhibit
  // ------------------------------------------------------------
  assign increment = pif.count_pulse & (inhibit_reg == 2'h0) & ~sleep
                   & ~wr_count; // RULE2 RULE11
  assign overflow = increment & (count_reg == 8'hFF); // RULE8

  always_ff @(posedge clk) begin
    if (rst) begin
      inhibit_reg <= 2'h0;
    end else if (wr_count) begin
      inhibit_reg <= timer_pkg::write_inhibit_cycles; // RULE2
    end else if (pif.q4 && inhibit_reg != 2'h0) begin
      inhibit_reg <= inhibit_reg - 2'h1; // RULE2
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= timer_pkg::rst_timer_count_value;
    end else if (wr_count) begin
      count_reg <= pwdata[7:0];
    end else if (increment) begin
      count_reg <= count_reg + 8'h01; // RULE1 RULE3 RULE13
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      options_reg <= timer_pkg::rst_timer_options;
    end else if (wr_options) begin
      options_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      porta_reg <= timer_pkg::rst_port_a_direction;
    end else if (wr_porta) begin
      porta_reg <= pwdata[7:0];
    end
  end

  // flag: write one clears, a new overflow wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      intctl_reg <= timer_pkg::rst_interrupt_control;
    end else begin
      if (wr_intctl) begin
        for (int i = 0; i < 8; i++) begin
          if (i != timer_pkg::pos_overflow_flag) begin
            intctl_reg[i] <= pwdata[i];
          end
        end
      end
      if (overflow) begin
        intctl_reg[timer_pkg::pos_overflow_flag] <= 1'b1; // RULE8 RULE10
      end else if (wr_intctl && pwdata[timer_pkg::pos_overflow_flag]) begin
        intctl_reg[timer_pkg::pos_overflow_flag] <= 1'b0; // RULE10
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt and watchdog outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
      wdt_tick_reg <= 1'b0;
      wdt_clear_reg <= 1'b0;
    end else begin
      irq_reg <= intctl_reg[timer_pkg::pos_overflow_flag]
               & intctl_reg[timer_pkg::pos_overflow_irq_enable]; // RULE9
      wdt_tick_reg <= pif.wdt_tick; // RULE5
      wdt_clear_reg <= watchdog_clear_instr; // RULE16
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign watchdog_tick = wdt_tick_reg;
  assign watchdog_clear = wdt_clear_reg;
  assign port_a_direction = porta_reg;
endmodule : timer_counter
`default_nettype wire

/* File: timer_counter_assertions.sv */
// port-level assertions for timer_counter
`default_nettype none
module timer_counter_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::addr_width-1:0] paddr,
  input wire logic [timer_pkg::data_width-1:0] pwdata,
  input wire logic [timer_pkg::data_width-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep,
  input wire logic irq,
  input wire logic watchdog_tick,
  input wire logic [7:0] port_a_direction
);
  // ----------
  // shadow of written enable and assignment bits
  // ----------
  logic wr_acc;
  logic [7:0] wdata_lo;
  logic enable_reg;
  logic to_wdt_reg;
  assign wr_acc = psel && penable && pready && pwrite;
  assign wdata_lo = pwdata[7:0];
  always_ff @(posedge clk) begin
    if (rst) begin
      enable_reg <= 1'b0;
    end else if (wr_acc && paddr == 12'h02C) begin
      enable_reg <= pwdata[5];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      to_wdt_reg <= 1'b1;
    end else if (wr_acc && paddr == 12'h204) begin
      to_wdt_reg <= pwdata[3];
    end
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held");
  a_unaligned_refused: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("unaligned access not refused");
  a_refused_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access with data");
  a_tick_needs_wdt: assert property (watchdog_tick |-> to_wdt_reg || $past(to_wdt_reg))
    else $error("watchdog tick while prescaler on counter");
  a_sleep_no_tick: assert property (sleep [*3] |-> !watchdog_tick)
    else $error("tick during sleep");
  a_irq_needs_enable: assert property (irq |-> $past(enable_reg))
    else $error("irq while masked");
  a_mask_drops_irq: assert property (wr_acc && paddr == 12'h02C && !pwdata[5] |=> ##1 !irq)
    else $error("irq not dropped by mask");
  a_dir_written: assert property (wr_acc && paddr == 12'h214 |=> port_a_direction == $past(wdata_lo))
    else $error("direction not written");
  c_irq: cover property (irq);
  c_refused: cover property (pslverr);
  c_tick: cover property (watchdog_tick);
endmodule : timer_counter_assertions
`default_nettype wire

/* File: pulse_source.sv */
// external pulse source on the count input pin
`default_nettype none
module pulse_source (
  input wire logic clk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'b0;
  // each level held 12 clocks, well over the sampling minimum
  task automatic drive(input logic lvl);
    @(posedge clk);
    pin <= lvl;
    repeat (12) @(posedge clk);
  endtask : drive
endmodule : pulse_source
`default_nettype wire

/* File: timer_counter_tb.sv */
// self-checking bench for timer_counter
`default_nettype none
module timer_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] a_cnt = 12'h004, a_ic = 12'h02C, a_opt = 12'h204, a_dir = 12'h214;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, e_;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, v, v2, r_;
  logic pready, pslverr, ext, otick = 0, wclr = 0, sleep = 0, irq, wtick, wco;
  logic [7:0] dir, opt;
  logic [15:0] lfsr = 16'hBE62;
  int mismatches = 0, tests_run = 0, ticks = 0, cnt, inh, phase, flag, snap;
  initial forever #2.5 clk = ~clk;
  timer_counter uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_input(ext), .watchdog_osc_tick(otick), .watchdog_clear_instr(wclr),
    .sleep(sleep), .irq(irq), .watchdog_tick(wtick), .watchdog_clear(wco),
    .port_a_direction(dir));
  pulse_source src (.clk(clk), .pin(ext));
  // ----------
  // reference model of count, flag and phase
  // ----------
  always @(posedge clk) begin
    if (psel && !penable) begin
      snap = cnt;
    end
    if (rst) begin
      cnt = 0;
      flag = 0;
      phase = 0;
      opt = 8'hFF;
    end else begin
      if (wtick) begin
        ticks++;
      end
      if (psel && penable && pready && pwrite && paddr == a_ic && pwdata[2]) begin
        flag = 0;
      end
      if (psel && penable && pready && pwrite && paddr == a_cnt) begin
        cnt = pwdata[7:0];
        inh = 2;
      end else if (phase == 3 && inh > 0) begin
        inh--;
      end else if (phase == 3 && !opt[5] && opt[3] && !sleep) begin
        cnt = (cnt + 1) % 256;
        flag |= (cnt == 0);
      end
      if (psel && penable && pready && pwrite && paddr == a_opt) begin
        opt = pwdata[7:0];
      end
      phase = (phase + 1) % 4;
    end
  end
  // ----------
  // bus and check tasks
  // ----------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r_ = prdata;
    e_ = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic cfg(input logic [31:0] o);
    pulse(1);
    apb(1, a_cnt, 0);
    apb(1, a_opt, o);
    apb(1, a_cnt, 0);
    repeat (20) @(posedge clk);
  endtask : cfg
  task automatic pulse(input bit wd);
    @(posedge clk);
    if (wd) begin
      wclr <= 1;
    end else begin
      otick <= 1;
    end
    @(posedge clk);
    wclr <= 0;
    otick <= 0;
    @(posedge clk);
    if (wd) begin
      chk(wco, 1);
    end
    repeat (5) @(posedge clk);
  endtask : pulse
  task automatic tally_and_finish;
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    mismatches++;
    tally_and_finish;
  end
  // ----------
  // scenarios
  // ----------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    foreach (v[i]) begin
      if (i < 4) begin
        apb(0, {a_cnt, a_ic, a_opt, a_dir} >> (36 - 12 * i), 0);
        chk(r_, i < 2 ? 32'h00 : 32'hFF);
      end
    end
    apb(0, 12'h000, 0);
    chk(r_, 32'h0);
    chk(e_, 1);
    lfsr = lfsr_next(lfsr);
    apb(1, a_dir, lfsr);
    apb(0, a_dir, 0);
    chk(r_, lfsr[7:0]);
    chk(dir, lfsr[7:0]);
    cfg(32'h08);
    apb(1, a_cnt, lfsr[15:8]);
    repeat (4) begin
      apb(0, a_cnt, 0);
      chk(r_, snap);
    end
    apb(1, a_ic, 32'h24);
    apb(1, a_cnt, 32'hFE);
    repeat (2) begin
      repeat (20) @(posedge clk);
      apb(0, a_ic, 0);
      chk(r_, 32'h20 | (flag << 2));
      chk(irq, flag);
    end
    apb(1, a_ic, 32'h00);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    apb(1, a_ic, 32'h04);
    apb(0, a_ic, 0);
    chk(r_, 32'h0);
    sleep <= 1;
    repeat (3) begin
      apb(0, a_cnt, 0);
      pulse(0);
      repeat (10) @(posedge clk);
      chk(r_, snap);
    end
    chk(ticks, 0);
    sleep <= 0;
    for (int r = 0; r < 8; r++) begin
      cfg(r);
      apb(0, a_cnt, 0);
      v = r_;
      repeat (1021) @(posedge clk);
      apb(0, a_cnt, 0);
      chk((r_ - v) & 32'hFF, 128 >> r);
    end
    for (int e = 0; e < 2; e++) begin
      cfg(32'h28 | (e << 4));
      apb(0, a_cnt, 0);
      v = r_;
      src.drive(1);
      apb(0, a_cnt, 0);
      v2 = r_;
      chk((v2 - v) & 32'hFF, e == 0);
      src.drive(0);
      apb(0, a_cnt, 0);
      chk((r_ - v2) & 32'hFF, e == 1);
    end
    cfg(32'h08);
    pulse(1);
    ticks = 0;
    pulse(0);
    pulse(1);
    repeat (3) pulse(0);
    repeat (20) @(posedge clk);
    chk(ticks, 3);
    tally_and_finish;
  end
endmodule : timer_counter_tb
bind timer_counter timer_counter_assertions chk_i (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sleep(sleep), .irq(irq),
  .watchdog_tick(watchdog_tick), .port_a_direction(port_a_direction));
`default_nettype wire
